/* File: dct_connectivity_test.sv */
module dct_connectivity_test
    import dct_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // Test pins
    input  wire logic        tenPin,
    input  wire logic        csN,
    input  wire logic [16:0] addrPin,
    input  wire logic [1:0]  baPin,
    input  wire logic [1:0]  bgPin,
    input  wire logic        actN,
    input  wire logic        ckePin,
    input  wire logic        odtPin,
    input  wire logic        ckT,
    input  wire logic        ckC,
    input  wire logic        lowMaskN,
    input  wire logic        upMaskN,
    input  wire logic        parityPin,
    input  wire logic        alertN,
    input  wire logic        resetPinN,
    // Straps
    input  wire logic [1:0]  orgSel,
    input  wire logic        testFitted,
    // Memory core side
    input  wire logic [15:0] coreDqOut,
    input  wire logic [15:0] coreDqOe,
    input  wire logic [3:0]  coreDqsOut,
    input  wire logic [3:0]  coreDqsOe,
    input  wire logic        coreOdtOn,
    // Pin drivers
    output logic      [15:0] dqOut,
    output logic      [15:0] dqOe,
    output logic      [3:0]  dqsOut,
    output logic      [3:0]  dqsOe,
    // Core control
    output logic             coreBypass,
    output logic             clkIgnore,
    output logic             odtEnable,
    output logic             refreshAllow,
    output logic             resetRequired
);
    import dct_pkg::*;

    typedef struct packed {
        logic [IN_W-1:0]  inS1;
        logic [IN_W-1:0]  inS2;
        dct_state_t       state;
        logic [CNT_W-1:0] cnt;
        logic             exitSeen;
        logic [15:0]      dqVal;
        logic [15:0]      dqEn;
        logic [3:0]       dqsVal;
        logic [3:0]       dqsEn;
    } dct_st_t;

    dct_st_t         st_q;
    dct_st_t         st_d;
    logic [IN_W-1:0] rawVec;
    logic [9:0]      mt;
    dct_org_t        org;
    logic            allowed;
    logic            tenOk;
    logic            testActive;

    assign rawVec = {testFitted, orgSel, csN, tenPin, resetPinN, alertN, parityPin, upMaskN, lowMaskN,
                     ckC, ckT, odtPin, ckePin, actN, bgPin, baPin, addrPin};

    // Shared RAS_n/A16 pin enters its term once; a double XOR would cancel it
    function automatic logic [9:0] calcMt(input logic [IN_W-1:0] v);
        logic [9:0] m;
        logic       x16;
        logic       x8;
        m   = 10'h000;
        x16 = (v[IX_ORG+:2] == ORG_X16);
        x8  = (v[IX_ORG+:2] == ORG_X8);
        m[0] = v[IX_ADDR+1] ^ v[IX_ADDR+6] ^ v[IX_PAR];
        m[1] = v[IX_ADDR+8] ^ v[IX_ALRT] ^ v[IX_ADDR+9];
        m[2] = v[IX_ADDR+2] ^ v[IX_ADDR+5] ^ v[IX_ADDR+15];
        m[3] = v[IX_ADDR+0] ^ v[IX_ADDR+7] ^ v[IX_ADDR+11];
        m[4] = v[IX_CKC] ^ v[IX_ODT] ^ v[IX_ADDR+15];
        m[5] = v[IX_CKE] ^ v[IX_ADDR+16] ^ v[IX_ADDR+10];
        m[6] = v[IX_ACT] ^ v[IX_ADDR+4] ^ v[IX_BA+1];
        m[7] = ((x16 & v[IX_UMSK]) | (!x16 & v[IX_BG+1]))
             ^ ((x8 | x16) & v[IX_LMSK]) ^ v[IX_CKT];
        m[8] = v[IX_ADDR+14] ^ v[IX_ADDR+12] ^ v[IX_BA];
        m[9] = v[IX_BG] ^ v[IX_ADDR+3] ^ (v[IX_RST] & v[IX_TEN]);
        return m;
    endfunction : calcMt

    assign mt       = calcMt(st_q.inS2);
    assign org      = dct_org_t'(st_q.inS2[IX_ORG+:2]);
    assign allowed  = (org == ORG_X16) || st_q.inS2[IX_FIT];
    assign tenOk    = st_q.inS2[IX_TEN] && allowed;
    assign testActive = (st_q.state == ST_ACTIVE);

    always_comb begin
        st_d      = st_q;
        st_d.inS1 = rawVec;
        st_d.inS2 = st_q.inS1;
        case (st_q.state)
            ST_NORMAL: begin
                st_d.cnt = '0;
                if (tenOk) begin
                    st_d.state = ST_ENTRY;
                end
            end
            ST_ENTRY: begin
                if (!tenOk) begin
                    st_d.state    = ST_NORMAL;
                    st_d.exitSeen = 1'b1;
                end else if (st_q.cnt == CNT_W'(ENTRY_WAIT - 1)) begin
                    st_d.state = ST_ACTIVE;
                end else begin
                    st_d.cnt = st_q.cnt + CNT_W'(1);
                end
            end
            ST_ACTIVE: begin
                if (!tenOk) begin
                    st_d.state    = ST_NORMAL;
                    st_d.exitSeen = 1'b1;
                end
            end
            default: begin
                st_d.state = ST_NORMAL;
            end
        endcase
        // Registered result, one cycle behind the synchronised inputs
        st_d.dqVal  = 16'h0000;
        st_d.dqEn   = 16'h0000;
        st_d.dqsVal = 4'h0;
        st_d.dqsEn  = 4'h0;
        case (org)
            ORG_X16: begin
                for (int i = 0; i < 6; i++) begin
                    st_d.dqVal[2*i]   = mt[i];
                    st_d.dqVal[2*i+1] = !mt[i];
                end
                st_d.dqVal[12]     = mt[6];
                st_d.dqVal[13]     = mt[7];
                st_d.dqVal[14]     = mt[8];
                st_d.dqVal[15]     = !mt[8];
                st_d.dqsVal[DQS_LT] = mt[9];
                st_d.dqsVal[DQS_LC] = !mt[9];
                st_d.dqsVal[DQS_UT] = !mt[9];
                st_d.dqsVal[DQS_UC] = mt[9];
                st_d.dqEn  = 16'hffff;
                st_d.dqsEn = 4'hf;
            end
            ORG_X8: begin
                st_d.dqVal[7:0]     = mt[7:0];
                st_d.dqsVal[DQS_LT] = mt[8];
                st_d.dqsVal[DQS_LC] = mt[9];
                st_d.dqEn  = 16'h00ff;
                st_d.dqsEn = 4'h3;
            end
            ORG_X4: begin
                for (int i = 0; i < 4; i++) begin
                    st_d.dqVal[i] = mt[2*i] ^ mt[2*i+1];
                end
                st_d.dqsVal[DQS_LT] = mt[8];
                st_d.dqsVal[DQS_LC] = mt[9];
                st_d.dqEn  = 16'h000f;
                st_d.dqsEn = 4'h3;
            end
            default: begin
                st_d.dqEn  = 16'h0000;
                st_d.dqsEn = 4'h0;
            end
        endcase
        if (!resetn) begin
            st_d = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        st_q <= st_d;
    end

    // Entry window also fences off the core, since its clock is already ignored
    assign coreBypass    = (st_q.state != ST_NORMAL);
    assign clkIgnore     = tenOk || coreBypass;
    assign odtEnable     = coreOdtOn && !clkIgnore;
    assign refreshAllow  = !clkIgnore;
    assign resetRequired = st_q.exitSeen;

    always_comb begin
        if (testActive) begin
            dqOut  = st_q.dqVal;
            dqsOut = st_q.dqsVal;
            dqOe   = st_q.inS2[IX_CS] ? 16'h0000 : st_q.dqEn;
            dqsOe  = st_q.inS2[IX_CS] ? 4'h0 : st_q.dqsEn;
        end else if (coreBypass) begin
            dqOut  = 16'h0000;
            dqsOut = 4'h0;
            dqOe   = 16'h0000;
            dqsOe  = 4'h0;
        end else begin
            dqOut  = coreDqOut;
            dqsOut = coreDqsOut;
            dqOe   = coreDqOe;
            dqsOe  = coreDqsOe;
        end
    end

    // Helper counters for the checks below
    logic [CNT_W-1:0] tenCnt_q;
    logic [2:0]       stabCnt_q;
    logic [IN_W-1:0]  rawPrev_q;
    localparam logic [CNT_W-1:0] CNT_MAX = '1;
    // Raw pin terms for the whole pin-to-output path, and min-term 0 from the synchronised inputs
    logic [9:0]       mtRaw;
    logic             mt0Ref;

    assign mtRaw  = calcMt(rawVec);
    assign mt0Ref = st_q.inS2[IX_ADDR+1] ^ st_q.inS2[IX_ADDR+6] ^ st_q.inS2[IX_PAR];

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            tenCnt_q  <= '0;
            stabCnt_q <= '0;
            rawPrev_q <= '0;
        end else begin
            rawPrev_q <= rawVec;
            if (!tenOk) begin
                tenCnt_q <= '0;
            end else if (tenCnt_q != CNT_MAX) begin
                tenCnt_q <= tenCnt_q + CNT_W'(1);
            end
            if (rawVec != rawPrev_q) begin
                stabCnt_q <= '0;
            end else if (stabCnt_q != 3'h7) begin
                stabCnt_q <= stabCnt_q + 3'h1;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_core_bypass: assert property (testActive |-> coreBypass && (dqOe[0] == !st_q.inS2[IX_CS]))
        else $error("Core not bypassed in test mode");
    // Entry tri-state keeps stale core data off the board
    a_entry_quiet: assert property (coreBypass && !testActive |-> dqOe == 16'h0000 && dqsOe == 4'h0)
        else $error("Test outputs driven during entry");
    a_cs_tristate: assert property (testActive && st_q.inS2[IX_CS] |-> dqOe == 16'h0000 && dqsOe == 4'h0)
        else $error("Test outputs driven with chip select high");
    a_result_follow: assert property (
        testActive && $past(testActive) && org == ORG_X16
        |-> dqOut[14:12] == $past(mt[8:6]) && dqsOut[DQS_LT] == $past(mt[9]))
        else $error("Result does not follow synchronised inputs");
    a_clk_ignore: assert property (tenOk |-> clkIgnore && !odtEnable)
        else $error("Clock not ignored with test enable high");
    a_entry_time: assert property (tenCnt_q == CNT_W'(ENTRY_WAIT + 1) |-> testActive)
        else $error("Test mode not entered in time");
    a_entry_early: assert property ($rose(testActive) |-> tenCnt_q == CNT_W'(ENTRY_WAIT + 1))
        else $error("Test mode entered at wrong time");
    // Five edges of stable pins lie well inside the output valid limit
    a_valid_bound: assert property (
        testActive && stabCnt_q == 3'h4 && org == ORG_X16
        |-> dqOut[0] == mtRaw[0] && dqsOut[DQS_LT] == mtRaw[9])
        else $error("Outputs not settled after stable inputs");

    a_odt_off: assert property (coreBypass |-> !odtEnable)
        else $error("Termination on in test mode");
    a_no_refresh: assert property (coreBypass |-> !refreshAllow)
        else $error("Refresh allowed in test mode");
    a_mt_zero: assert property (
        testActive && $past(testActive) && org == ORG_X16 |-> dqOut[0] == $past(mt0Ref))
        else $error("Min-term zero wrong");
    a_x16_pairs: assert property (
        testActive && org == ORG_X16
        |-> dqOut[1] == !dqOut[0] && dqOut[15] == !dqOut[14] && dqsOut[DQS_UT] == !dqsOut[DQS_LT])
        else $error("x16 inverted pairs wrong");
    a_x16_enable: assert property (
        testActive && org == ORG_X16 && !st_q.inS2[IX_CS] |-> dqOe == 16'hffff && dqsOe == 4'hf)
        else $error("x16 outputs not all driven");
    a_x8_terms: assert property (
        testActive && $past(testActive) && org == ORG_X8
        |-> dqOut[7:0] == $past(mt[7:0]) && dqsOut[DQS_LC] == $past(mt[9]))
        else $error("x8 mapping wrong");
    a_x8_enable: assert property (
        testActive && org == ORG_X8 && !st_q.inS2[IX_CS] |-> dqOe == 16'h00ff && dqsOe == 4'h3)
        else $error("x8 output enables wrong");
    a_x4_terms: assert property (
        testActive && $past(testActive) && org == ORG_X4
        |-> dqOut[0] == $past(mt[0] ^ mt[1]) && dqOe[15:4] == 12'h000)
        else $error("x4 mapping wrong");
    // Unfitted x8 and x4 parts must never leave normal mode, whatever the enable does
    a_fit_gate: assert property (!allowed |=> st_q.state == ST_NORMAL)
        else $error("Test mode entered when not fitted");
    a_normal_pass: assert property (!coreBypass |-> dqOut == coreDqOut && dqOe == coreDqOe)
        else $error("Normal pins disturbed");
    a_normal_strobe: assert property (!coreBypass |-> dqsOut == coreDqsOut && dqsOe == coreDqsOe)
        else $error("Normal strobes disturbed");

    c_enter_x16: cover property ($rose(testActive) && org == ORG_X16);
    c_enter_x4: cover property ($rose(testActive) && org == ORG_X4);
    c_cs_toggle: cover property (testActive && $fell(st_q.inS2[IX_CS]));
    c_exit_mode: cover property ($fell(testActive) ##1 resetRequired);
    c_abort_entry: cover property (st_q.state == ST_ENTRY && !tenOk);
endmodule : dct_connectivity_test

/* File: dct_pkg.sv */
// Operation
// - Test enable high bypasses memory core; IO pins become parallel test inputs and outputs.
// - Test outputs driven only while chip select low, otherwise tri-stated.
// - Test mode is combinational-like: fixed delay from inputs to outputs.
// - On test enable, ignore clocks; test mode reached within 200 ns.
// - Outputs stable within 200 ns of new inputs, enable high, CS low.
// - All on-die termination off during test mode.
// - No array refresh, external or self-timed, during test mode.
// - Min-terms 0-5 are the listed three or four input XORs.
// - Min-terms 6, 7, 8 are the listed XORs, 7 width dependent.
// - Min-term 9 is XOR of BG0, A3 and reset AND test enable.
// - x16: even DQ0-10 carry min-terms 0-5, next odd DQ inverted.
// - x16: DQ12-14 carry 6-8, DQ15 inverted, strobes from min-term 9.
// - x8: DQ0-7 carry min-terms 0-7, strobe pair carries 8 and 9.
// - x4: DQ0-3 carry XOR of min-term pairs, strobes carry 8 and 9.
// - Test mode always on x16, optional on x8 and x4.
package dct_pkg;
    typedef enum logic [1:0] {
        ORG_X4  = 2'h0,
        ORG_X8  = 2'h1,
        ORG_X16 = 2'h2
    } dct_org_t;

    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_ENTRY,
        ST_ACTIVE
    } dct_state_t;

    localparam int CLK_PERIOD_NS   = 5;
    localparam int ENTRY_NS        = 200;
    localparam int VALID_NS        = 200;
    localparam int ENTRY_CYC       = ENTRY_NS / CLK_PERIOD_NS;
    localparam int VALID_CYC       = VALID_NS / CLK_PERIOD_NS;
    localparam int SYNC_LAT        = 3;
    localparam int ENTRY_WAIT      = ENTRY_CYC - SYNC_LAT;
    localparam int CNT_W           = 7;

    localparam int IX_ADDR = 0;
    localparam int IX_BA   = 17;
    localparam int IX_BG   = 19;
    localparam int IX_ACT  = 21;
    localparam int IX_CKE  = 22;
    localparam int IX_ODT  = 23;
    localparam int IX_CKT  = 24;
    localparam int IX_CKC  = 25;
    localparam int IX_LMSK = 26;
    localparam int IX_UMSK = 27;
    localparam int IX_PAR  = 28;
    localparam int IX_ALRT = 29;
    localparam int IX_RST  = 30;
    localparam int IX_TEN  = 31;
    localparam int IX_CS   = 32;
    localparam int IX_ORG  = 33;
    localparam int IX_FIT  = 35;
    localparam int IN_W    = 36;

    localparam int DQS_LT = 0;
    localparam int DQS_LC = 1;
    localparam int DQS_UT = 2;
    localparam int DQS_UC = 3;
endpackage : dct_pkg

/* File: dct_scan_agent.sv */
module dct_scan_agent (
    // Clock
    input  wire logic        core_clk,
    // Test pins
    output logic             tenPin,
    output logic             csN,
    output logic      [16:0] addrPin,
    output logic      [1:0]  baPin,
    output logic      [1:0]  bgPin,
    output logic             actN,
    output logic             ckePin,
    output logic             odtPin,
    output logic             ckT,
    output logic             ckC,
    output logic             lowMaskN,
    output logic             upMaskN,
    output logic             parityPin,
    output logic             alertN,
    output logic             resetPinN,
    // Straps
    output logic      [1:0]  orgSel,
    output logic             testFitted
);
    timeunit 1ns;
    timeprecision 1ps;
    import dct_pkg::*;

    logic [IN_W-1:0] pat;

    // Idle: enable low, deselected, reset pin high, x16 strap
    initial pat = 36'h5_4000_0000;

    // Pins, the enable among them, move just after an edge only
    task automatic apply(input logic [IN_W-1:0] v);
        @(posedge core_clk);
        pat <= v;
    endtask : apply

    assign tenPin    = pat[IX_TEN];
    assign csN       = pat[IX_CS];
    assign addrPin   = pat[IX_ADDR +: 17];
    assign baPin     = pat[IX_BA +: 2];
    assign bgPin     = pat[IX_BG +: 2];
    assign actN      = pat[IX_ACT];
    assign ckePin    = pat[IX_CKE];
    assign odtPin    = pat[IX_ODT];
    assign ckT       = pat[IX_CKT];
    assign ckC       = pat[IX_CKC];
    assign lowMaskN  = pat[IX_LMSK];
    assign upMaskN   = pat[IX_UMSK];
    assign parityPin = pat[IX_PAR];
    assign alertN    = pat[IX_ALRT];
    assign resetPinN = pat[IX_RST];
    assign orgSel    = pat[IX_ORG +: 2];
    assign testFitted = pat[IX_FIT];
endmodule : dct_scan_agent

/* File: tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dct_pkg::*;

    localparam int LIMIT = 6000;
    logic        core_clk, resetn, tenPin, csN, actN, ckePin, odtPin, ckT, ckC, lowMaskN, upMaskN;
    logic        parityPin, alertN, resetPinN, testFitted, coreOdtOn;
    logic [16:0] addrPin;
    logic [1:0]  baPin, bgPin, orgSel;
    logic [15:0] coreDqOut, coreDqOe, dqOut, dqOe;
    logic [3:0]  coreDqsOut, coreDqsOe, dqsOut, dqsOe;
    logic        coreBypass, clkIgnore, odtEnable, refreshAllow, resetRequired;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cycles = 0;

    dct_connectivity_test u_dct_connectivity_test (.*);
    dct_scan_agent u_dct_scan_agent (.*);

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors++;
            results();
        end
    end

    task automatic results();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    task automatic chk_vec(input string what, input logic [19:0] exp, input logic [19:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_vec

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc

    task automatic do_reset();
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
    endtask : do_reset

    function automatic logic [35:0] mk(logic [1:0] org, logic fit, logic test_mode_enable_pin, logic cs, logic [29:0] ti);
        return {fit, org, cs, test_mode_enable_pin, 1'b1, ti};
    endfunction : mk

    // Returns {enables, levels}, levels masked by enables
    function automatic logic [39:0] expect_pins(logic [35:0] v);
        logic [16:0] a;
        logic [9:0]  mt;
        logic [19:0] d;
        logic [19:0] oe;
        logic        x16;
        logic        x8;
        a = v[16:0];
        x16 = (v[IX_ORG +: 2] == 2'h2);
        x8 = (v[IX_ORG +: 2] == 2'h1);
        mt[0] = a[1] ^ a[6] ^ v[IX_PAR];
        mt[1] = a[8] ^ v[IX_ALRT] ^ a[9];
        mt[2] = a[2] ^ a[5] ^ a[15];
        mt[3] = a[0] ^ a[7] ^ a[11];
        mt[4] = v[IX_CKC] ^ v[IX_ODT] ^ a[15];
        mt[5] = v[IX_CKE] ^ a[16] ^ a[10];
        mt[6] = v[IX_ACT] ^ a[4] ^ v[IX_BA + 1];
        mt[7] = (x16 ? v[IX_UMSK] : v[IX_BG + 1]) ^ ((x8 | x16) & v[IX_LMSK]) ^ v[IX_CKT];
        mt[8] = a[14] ^ a[12] ^ v[IX_BA];
        mt[9] = v[IX_BG] ^ a[3] ^ (v[IX_RST] & v[IX_TEN]);
        d = '0;
        if (x16) begin
            for (int i = 0; i < 6; i++) begin
                d[2*i] = mt[i];
                d[2*i+1] = ~mt[i];
            end
            d[15:12] = {~mt[8], mt[8:6]};
            d[19:16] = {mt[9], ~mt[9], ~mt[9], mt[9]};
            oe = 20'hfffff;
        end else if (x8) begin
            d[7:0] = mt[7:0];
            d[17:16] = mt[9:8];
            oe = 20'h300ff;
        end else begin
            for (int i = 0; i < 4; i++) begin
                d[i] = mt[2*i] ^ mt[2*i+1];
            end
            d[17:16] = mt[9:8];
            oe = 20'h3000f;
        end
        if (v[IX_CS]) begin
            oe = '0;
        end
        return {oe, d & oe};
    endfunction : expect_pins

    task automatic chk_pins(input logic [35:0] v);
        logic [39:0] e;
        e = expect_pins(v);
        chk_vec("pin enables", e[39:20], {dqsOe, dqOe});
        chk_vec("pin levels", e[19:0], {dqsOut, dqOut} & e[39:20]);
    endtask : chk_pins

    task automatic chk_core();
        chk_vec("pin enables", {coreDqsOe, coreDqOe}, {dqsOe, dqOe});
        chk_vec("pin levels", {coreDqsOut, coreDqOut}, {dqsOut, dqOut});
    endtask : chk_core

    task automatic s_normal();
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            coreDqOut <= k ? 16'h5a3c : 16'ha5c3;
            coreDqOe <= k ? 16'hf0f0 : 16'h0ff1;
            coreDqsOut <= k ? 4'h9 : 4'h6;
            coreDqsOe <= k ? 4'hc : 4'h3;
            coreOdtOn <= k[0];
            wait_cyc(2);
            chk_core();
            chk_bit("odt", k[0], odtEnable);
            chk_bit("refresh", 1'b1, refreshAllow);
            chk_bit("bypass", 1'b0, coreBypass);
        end
    endtask : s_normal

    task automatic s_test(input logic [1:0] org, input logic fit);
        logic [35:0] v;
        do_reset();
        u_dct_scan_agent.apply(mk(org, fit, 1'b1, 1'b0, 30'h0));
        wait_cyc(ENTRY_CYC);
        chk_bit("bypass", 1'b1, coreBypass);
        chk_bit("clock ignore", 1'b1, clkIgnore);
        chk_bit("odt", 1'b0, odtEnable);
        chk_bit("refresh", 1'b0, refreshAllow);
        chk_pins(mk(org, fit, 1'b1, 1'b0, 30'h0));
        // Walking one drives each of the 30 low pattern bits in turn and checks the pins against expect_pins
        for (int k = 0; k < 30; k++) begin
            v = mk(org, fit, 1'b1, 1'b0, 30'h1 << k);
            u_dct_scan_agent.apply(v);
            wait_cyc(VALID_CYC);
            chk_pins(v);
        end
        v = mk(org, fit, 1'b1, 1'b1, 30'h2aaaaaaa);
        u_dct_scan_agent.apply(v);
        wait_cyc(VALID_CYC);
        chk_pins(v);
        u_dct_scan_agent.apply(mk(org, fit, 1'b0, 1'b0, 30'h0));
        wait_cyc(4);
        chk_bit("bypass", 1'b0, coreBypass);
        chk_bit("reset needed", 1'b1, resetRequired);
        chk_core();
    endtask : s_test

    task automatic s_refuse();
        for (int k = 0; k < 2; k++) begin
            do_reset();
            u_dct_scan_agent.apply(mk(k ? ORG_X4 : ORG_X8, 1'b0, 1'b1, 1'b0, 30'h155));
            wait_cyc(ENTRY_CYC + 4);
            chk_bit("bypass", 1'b0, coreBypass);
            chk_core();
        end
    endtask : s_refuse

    task automatic s_abort();
        do_reset();
        u_dct_scan_agent.apply(mk(ORG_X16, 1'b1, 1'b1, 1'b0, 30'h0));
        wait_cyc(10);
        chk_bit("bypass", 1'b1, coreBypass);
        u_dct_scan_agent.apply(mk(ORG_X16, 1'b1, 1'b0, 1'b0, 30'h0));
        wait_cyc(6);
        chk_bit("bypass", 1'b0, coreBypass);
        chk_bit("reset needed", 1'b1, resetRequired);
        do_reset();
        wait_cyc(1);
        chk_bit("reset needed", 1'b0, resetRequired);
    endtask : s_abort

    initial begin
        resetn = 1'b0;
        coreDqOut = 16'h0000;
        coreDqOe = 16'h0000;
        coreDqsOut = 4'h0;
        coreDqsOe = 4'h0;
        coreOdtOn = 1'b0;
        do_reset();
        s_normal();
        s_test(ORG_X16, 1'b0);
        s_test(ORG_X8, 1'b1);
        s_test(ORG_X4, 1'b1);
        s_refuse();
        s_abort();
        results();
    end
endmodule : tb_top
